// *** core/ievf_pkg.sv ***
// Constants and record types for the input event filter with its event record log.
package ievf_pkg;
  localparam int IEVF_INPUTS = 20;
  localparam int FILTER_LIMIT = 200;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CHAT_UNIT_MS = 100;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int IDX_W = 5;
  localparam int TS_W = 64;
  localparam int DEB_W = 15;
  localparam int CT_W = 16;
  localparam int CC_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Address layout: kind in the top three bits, input index in the low five.
  localparam int KIND_MSB = 7;
  localparam int KIND_LSB = 5;
  localparam logic [2:0] KIND_DEB = 3'h0;
  localparam logic [2:0] KIND_CHT = 3'h1;
  localparam logic [2:0] KIND_CMAX = 3'h2;
  localparam logic [2:0] KIND_BLK = 3'h3;
  localparam logic [2:0] KIND_STAT = 3'h4;
  localparam logic [2:0] KIND_LOG = 3'h5;
  localparam int DEB_INV_BIT = 15;
  localparam int LOG_OVF_BIT = 8;
  localparam logic [CC_W-1:0] CMAX_RST = 8'h01;
  localparam logic [DEB_W-1:0] DEB_RST = 15'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ievf_bus_req_t;

  typedef struct packed {
    logic value;
    logic blocked;
    logic overflow;
    logic [IDX_W-1:0] src;
    logic [TS_W-1:0] stamp;
  } ievf_rec_t;
endpackage

// *** core/ievf_top.sv ***
// Input event filter: inversion, debounce, chatter filter and the event record log.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module ievf_top
  import ievf_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
)(
  input wire logic core_clk_i, // Module clock, 20 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic [IEVF_INPUTS-1:0] din_i, // Field inputs, asynchronous.
  input wire ievf_bus_req_t reg_req_i, // Register port request.
  output logic [DATA_W-1:0] reg_rdata_o, // Read data, cycle after the read strobe.
  input wire logic rec_req_i, // Reader asks for the next record.
  output ievf_rec_t rec_o, // Record presented to the reader.
  output logic rec_valid_o // Record valid, one cycle.
);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(IEVF_INPUTS - 1);
  localparam logic [FIFO_AW:0] FIFO_FULL_LVL = (FIFO_AW + 1)'(FIFO_DEPTH);

  logic [IEVF_INPUTS-1:0] sync1, sync2, sync3, pin_val;
  logic [31:0] pre_cnt;
  logic [6:0] hms_cnt;
  logic ms_tick, hms_tick;
  logic [TS_W-1:0] now_ms;
  logic [IEVF_INPUTS-1:0] inv;
  logic [DEB_W-1:0] deb_t [IEVF_INPUTS];
  logic [CT_W-1:0] cht_t [IEVF_INPUTS];
  logic [CC_W-1:0] cht_max [IEVF_INPUTS];
  logic [CT_W-1:0] blk_t [IEVF_INPUTS];
  logic [IEVF_INPUTS-1:0] dval, run, blk, ms_pend, hms_pend;
  logic [DEB_W-1:0] dtmr [IEVF_INPUTS];
  logic [TS_W-1:0] pts [IEVF_INPUTS];
  logic [CT_W-1:0] stab [IEVF_INPUTS];
  logic [CC_W-1:0] ccnt [IEVF_INPUTS];
  logic [CT_W-1:0] btmr [IEVF_INPUTS];
  logic [IDX_W-1:0] idx;
  ievf_rec_t mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wp, rp;
  logic [FIFO_AW:0] lvl;
  logic ovf_pend;

  // Pins pass three flops; the filtered pin only moves when stages two and three agree.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_val <= '0;
    end
    else
    begin
      sync1 <= din_i;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_val <= (sync3 & ~(sync2 ^ sync3)) | (pin_val & (sync2 ^ sync3));
    end
  end

  // Millisecond time base and the 100 ms chatter unit.
  assign ms_tick = (pre_cnt == 32'(MS_CYCLES - 1));
  assign hms_tick = ms_tick && (hms_cnt == 7'(CHAT_UNIT_MS - 1));

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pre_cnt <= '0;
      hms_cnt <= '0;
      now_ms <= '0;
    end
    else
    begin
      pre_cnt <= ms_tick ? '0 : pre_cnt + 32'h00000001;
      if (ms_tick)
      begin
        hms_cnt <= hms_tick ? '0 : hms_cnt + 7'h01;
        now_ms <= now_ms + 64'h0000000000000001;
      end
    end
  end

  // Inputs are visited one per cycle, so at most one event is born per cycle.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      idx <= '0;
    else
      idx <= (idx == LAST_IDX) ? '0 : idx + 5'h01;
  end

  // Ticks are parked per input until its visit; a tick in the visit cycle is kept.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ms_pend <= '0;
      hms_pend <= '0;
    end
    else
    begin
      ms_pend[idx] <= 1'b0;
      hms_pend[idx] <= 1'b0;
      if (ms_tick)
        ms_pend <= '1;
      if (hms_tick)
        hms_pend <= '1;
    end
  end

  // Configuration registers, one set per input.
  wire [2:0] wkind = reg_req_i.addr[KIND_MSB:KIND_LSB];
  wire [IDX_W-1:0] widx = reg_req_i.addr[IDX_W-1:0];
  wire widx_ok = (widx <= LAST_IDX);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      inv <= '0;
      for (int i = 0; i < IEVF_INPUTS; i++)
      begin
        deb_t[i] <= DEB_RST;
        cht_t[i] <= '0;
        cht_max[i] <= CMAX_RST;
        blk_t[i] <= '0;
      end
    end
    else if (reg_req_i.wr && widx_ok)
    begin
      unique case (wkind)
        KIND_DEB:
        begin
          inv[widx] <= reg_req_i.wdata[DEB_INV_BIT];
          deb_t[widx] <= reg_req_i.wdata[DEB_W-1:0];
        end
        KIND_CHT: cht_t[widx] <= reg_req_i.wdata[CT_W-1:0];
        KIND_CMAX: cht_max[widx] <= reg_req_i.wdata[CC_W-1:0];
        KIND_BLK: blk_t[widx] <= reg_req_i.wdata[CT_W-1:0];
        default: ;
      endcase
    end
  end

  logic [DATA_W-1:0] next_rdata;
  always_comb
  begin
    next_rdata = '0;
    if (widx_ok)
    begin
      unique case (wkind)
        KIND_DEB: next_rdata = DATA_W'({inv[widx], deb_t[widx]});
        KIND_CHT: next_rdata = DATA_W'(cht_t[widx]);
        KIND_CMAX: next_rdata = DATA_W'(cht_max[widx]);
        KIND_BLK: next_rdata = DATA_W'(blk_t[widx]);
        KIND_STAT: next_rdata = DATA_W'({blk[widx], dval[widx]});
        KIND_LOG: next_rdata = (widx == '0) ? DATA_W'({ovf_pend, (LOG_OVF_BIT - FIFO_AW - 1)'(1'b0), lvl}) : '0;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= '0;
    else
      reg_rdata_o <= reg_req_i.rd ? next_rdata : '0;
  end

  // Filter chain for the visited input.
  wire cur_raw = pin_val[idx] ^ inv[idx];
  wire filt_ok = (32'(idx) < FILTER_LIMIT);
  wire deb_on = filt_ok && (deb_t[idx] != '0);
  wire cht_on = filt_ok && (cht_t[idx] != '0);
  wire cur_blk = blk[idx];
  wire cur_run = run[idx];
  logic fwd, start, cancel, enter, expire, ev_valid;
  logic [TS_W-1:0] fwd_ts;
  ievf_rec_t ev;

  always_comb
  begin
    fwd = 1'b0;
    start = 1'b0;
    cancel = 1'b0;
    fwd_ts = now_ms;
    if (!deb_on)
      fwd = (cur_raw != dval[idx]);
    else if (cur_run)
    begin
      if (cur_raw == dval[idx])
        cancel = 1'b1;
      else if (ms_pend[idx] && dtmr[idx] <= 15'h0001)
      begin
        fwd = 1'b1;
        fwd_ts = pts[idx];
      end
    end
    else if (cur_raw != dval[idx])
      start = 1'b1;
  end

  // A short stable interval counts; exceeding the maximum starts blocking.
  assign enter = fwd && !cur_blk && cht_on && (stab[idx] < cht_t[idx])
                 && (ccnt[idx] >= cht_max[idx]);
  assign expire = cur_blk && hms_pend[idx] && (btmr[idx] <= 16'h0001);
  assign ev_valid = (fwd && !cur_blk) || expire;

  always_comb
  begin
    ev.value = fwd ? cur_raw : dval[idx];
    ev.blocked = enter;
    ev.overflow = ovf_pend;
    ev.src = idx;
    ev.stamp = expire ? now_ms : fwd_ts;
  end

  // Debounce state.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dval <= '0;
      run <= '0;
      for (int i = 0; i < IEVF_INPUTS; i++)
      begin
        dtmr[i] <= '0;
        pts[i] <= '0;
      end
    end
    else
    begin
      if (fwd)
      begin
        dval[idx] <= cur_raw;
        run[idx] <= 1'b0;
      end
      else if (cancel)
        run[idx] <= 1'b0;
      else if (start)
      begin
        run[idx] <= 1'b1;
        dtmr[idx] <= deb_t[idx];
        pts[idx] <= now_ms;
      end
      else if (cur_run && ms_pend[idx])
        dtmr[idx] <= dtmr[idx] - 15'h0001;
    end
  end

  // Chatter state: stable time, short-interval count, blocking and its timer.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blk <= '0;
      for (int i = 0; i < IEVF_INPUTS; i++)
      begin
        stab[i] <= '0;
        ccnt[i] <= '0;
        btmr[i] <= '0;
      end
    end
    else
    begin
      if (fwd)
        stab[idx] <= '0;
      else if (hms_pend[idx] && stab[idx] != '1)
        stab[idx] <= stab[idx] + 16'h0001;
      if (expire || enter)
        ccnt[idx] <= '0;
      else if (fwd && !cur_blk && cht_on)
        ccnt[idx] <= (stab[idx] < cht_t[idx]) ? ccnt[idx] + 8'h01 : '0;
      else if (hms_pend[idx] && stab[idx] >= cht_t[idx])
        ccnt[idx] <= '0;
      if (enter)
      begin
        blk[idx] <= 1'b1;
        btmr[idx] <= blk_t[idx];
      end
      else if (expire)
        blk[idx] <= 1'b0;
      else if (cur_blk && hms_pend[idx])
        btmr[idx] <= btmr[idx] - 16'h0001;
    end
  end

  // Event record log.
  wire full = (lvl == FIFO_FULL_LVL);
  wire empty = (lvl == '0);
  wire push = ev_valid && !full;
  wire drop = ev_valid && full;
  wire pop = rec_req_i && !empty;

  always_ff @(posedge core_clk_i)
  begin
    if (push)
      mem[wp] <= ev;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp <= '0;
      rp <= '0;
      lvl <= '0;
      ovf_pend <= 1'b0;
    end
    else
    begin
      if (push)
        wp <= wp + 4'h1;
      if (pop)
        rp <= rp + 4'h1;
      lvl <= lvl + (FIFO_AW + 1)'(push) - (FIFO_AW + 1)'(pop);
      if (drop)
        ovf_pend <= 1'b1;
      else if (push)
        ovf_pend <= 1'b0;
    end
  end

  // The record is held until the next pop; rec_valid_o marks it for one cycle only.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rec_o <= '0;
      rec_valid_o <= 1'b0;
    end
    else
    begin
      rec_valid_o <= pop;
      if (pop)
        rec_o <= mem[rp];
    end
  end

  default clocking dflt_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_rec_one_cycle: assert property (rec_valid_o |-> $past(rec_req_i) && $past(!empty))
    else $error("Record shown without a reader request.");
  chk_stamp_step: assert property (ms_tick |=> now_ms == $past(now_ms) + 64'h0000000000000001)
    else $error("Timestamp did not advance by one millisecond.");
  chk_deb_bypass: assert property (!deb_on && !cur_blk && cur_raw != dval[idx]
    |-> ev_valid && ev.stamp == now_ms)
    else $error("Change with debounce off was not logged at once.");
  chk_deb_hold: assert property (deb_on && !cur_run && cur_raw != dval[idx] |-> !ev_valid || expire)
    else $error("Debounce start produced an event.");
  chk_deb_cancel: assert property (cancel |=> !run[$past(idx)])
    else $error("Debounce timer not cancelled.");
  chk_deb_stamp: assert property (deb_on && fwd && !cur_blk |-> ev.stamp == pts[idx])
    else $error("Debounced event lost its first-seen time.");
  chk_block_drop: assert property (cur_blk && !expire |-> !ev_valid)
    else $error("Event escaped a blocking input.");
  chk_block_enter: assert property (enter |-> ev_valid && ev.blocked ##1 blk[$past(idx)])
    else $error("Blocking entry not recorded.");
  chk_ovf_flag: assert property (drop |=> ovf_pend)
    else $error("Dropped event did not raise overflow.");
  chk_ovf_carry: assert property (push && ovf_pend |-> ev.overflow ##1 !ovf_pend || drop)
    else $error("Overflow flag not carried by the next record.");

  cov_block_enter: cover property (enter);
  cov_block_leave: cover property (expire);
  cov_log_drop: cover property (drop);
  cov_rec_read: cover property (rec_valid_o);
endmodule

// *** verification/ievf_reader.sv ***
// Reader application model: pulls one record per request from the event record log.
`timescale 1ns/100ps
module ievf_reader
  import ievf_pkg::*;
(
  input wire logic core_clk_i, // Module clock.
  input wire ievf_rec_t rec_i, // Record from the log.
  input wire logic rec_valid_i, // Record valid pulse.
  output logic rec_req_o // Pull request pulse.
);
  initial rec_req_o = 1'b0;

  // The record is taken only in its valid cycle, since the log may replace it on the next pull.
  task automatic pull(output logic got, output ievf_rec_t rec);
    @(posedge core_clk_i);
    rec_req_o <= 1'b1;
    @(posedge core_clk_i);
    rec_req_o <= 1'b0;
    @(negedge core_clk_i);
    got = rec_valid_i;
    rec = rec_i;
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking testbench for the input event filter and its event record log.
`timescale 1ns/100ps
module tb;
  import ievf_pkg::*;
  // Short millisecond so the 100 ms chatter units fit a short run.
  localparam int MS = 25;
  logic core_clk_i;
  logic rst_i;
  logic [IEVF_INPUTS-1:0] din;
  ievf_bus_req_t reg_req;
  logic [DATA_W-1:0] reg_rdata;
  logic rec_req;
  ievf_rec_t rec;
  logic rec_valid;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0 = 0;

  ievf_top #(.MS_CYCLES(MS)) u_ievf_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .din_i(din),
    .reg_req_i(reg_req), .reg_rdata_o(reg_rdata), .rec_req_i(rec_req), .rec_o(rec), .rec_valid_o(rec_valid));
  ievf_reader u_ievf_reader (.core_clk_i(core_clk_i), .rec_i(rec), .rec_valid_i(rec_valid), .rec_req_o(rec_req));

  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) cyc <= cyc + 1;

  function automatic int ms_now();
    return (cyc - t0) / MS;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] kind, input logic [4:0] idx, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_req <= '{addr: {kind, idx}, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    reg_req <= '0;
  endtask

  task automatic reg_rd(input logic [2:0] kind, input logic [4:0] idx, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_req <= '{addr: {kind, idx}, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    reg_req <= '0;
    @(negedge core_clk_i);
    d = reg_rdata;
  endtask

  // Polls the log until a record comes; long enough to cover one block time.
  task automatic get_rec(output ievf_rec_t r);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 3000 && got !== 1'b1; i++)
      u_ievf_reader.pull(got, r);
    check(got, 1'b1);
  endtask

  task automatic toggle(input int idx, input int wait_cyc);
    @(posedge core_clk_i);
    din[idx] <= ~din[idx];
    repeat (wait_cyc) @(posedge core_clk_i);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #2000000;
    n_fail++;
    close_out();
  end

  initial
  begin
    ievf_rec_t r;
    logic [31:0] d;
    logic got;
    int tms;
    rst_i = 1'b1;
    din = '0;
    reg_req = '0;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t0 = cyc + 1;
    reg_rd(KIND_DEB, 5'h04, d);
    check(d, 32'h0);
    reg_rd(KIND_CMAX, 5'h04, d);
    check(d, {24'h0, CMAX_RST});
    reg_wr(KIND_DEB, 5'h02, 32'h7fff);
    reg_wr(KIND_DEB, 5'h14, 32'h7fff);
    reg_rd(KIND_DEB, 5'h02, d);
    check(d, 32'h7fff);
    reg_rd(KIND_DEB, 5'h03, d);
    check(d, 32'h0);
    reg_rd(KIND_DEB, 5'h14, d);
    check(d, 32'h0);
    // Unfiltered input: the change goes straight to the log with the time it was seen.
    @(posedge core_clk_i);
    din[3] <= 1'b1;
    tms = ms_now();
    get_rec(r);
    check({r.value, r.blocked, r.overflow, r.src}, {3'h4, 5'h03});
    check(64'(r.stamp >= tms && r.stamp <= tms + 1), 64'h1);
    // Inversion on input 5.
    reg_wr(KIND_DEB, 5'h05, 32'h8000);
    repeat (40) @(posedge core_clk_i);
    get_rec(r);
    check({r.value, r.src}, {1'b1, 5'h05});
    toggle(5, 0);
    get_rec(r);
    check({r.value, r.src}, {1'b0, 5'h05});
    // Debounce of 3 ms on input 7: a 1 ms pulse is cancelled, a held change is forwarded late.
    reg_wr(KIND_DEB, 5'h07, 32'h3);
    toggle(7, MS);
    toggle(7, 5 * MS);
    u_ievf_reader.pull(got, r);
    check(got, 1'b0);
    tms = ms_now();
    toggle(7, MS);
    u_ievf_reader.pull(got, r);
    check(got, 1'b0);
    get_rec(r);
    check({r.value, r.blocked, r.src}, {2'h2, 5'h07});
    check(64'(r.stamp >= tms && r.stamp <= tms + 1), 64'h1);
    // Chatter on input 9: time 100 ms, max 1, block 100 ms; four changes 2 ms apart.
    reg_wr(KIND_CHT, 5'h09, 32'h1);
    reg_wr(KIND_CMAX, 5'h09, 32'h1);
    reg_wr(KIND_BLK, 5'h09, 32'h1);
    repeat (250 * MS) @(posedge core_clk_i);
    while ((cyc - t0) % (100 * MS) != 100) @(posedge core_clk_i);
    for (int i = 0; i < 4; i++)
      toggle(9, 2 * MS);
    reg_rd(KIND_STAT, 5'h09, d);
    check(d, 32'h2);
    get_rec(r);
    check({r.value, r.blocked}, 2'h2);
    get_rec(r);
    check({r.value, r.blocked}, 2'h0);
    get_rec(r);
    check({r.value, r.blocked}, 2'h3);
    get_rec(r);
    check({r.value, r.blocked, r.src}, {2'h0, 5'h09});
    // Eighteen changes with the reader idle: sixteen kept, two dropped.
    for (int i = 0; i < 18; i++)
      toggle(0, 40);
    reg_rd(KIND_LOG, 5'h00, d);
    check(d, 32'h110);
    for (int i = 0; i < 16; i++)
    begin
      get_rec(r);
      check({r.value, r.overflow, r.src}, {~i[0], 6'h00});
    end
    u_ievf_reader.pull(got, r);
    check(got, 1'b0);
    toggle(0, 0);
    get_rec(r);
    check({r.value, r.overflow}, 2'h3);
    @(negedge core_clk_i);
    check(rec_valid, 1'b0);
    close_out();
  end
endmodule
